// >>> hdl/motor_param_regs.vh
// constants for the motor parameter code decoder
`ifndef MOTOR_PARAM_REGS_VH
`define MOTOR_PARAM_REGS_VH
`define CODE_W 7
`define MANT_LSB 0
`define MANT_W 4
`define EXP_LSB 4
`define EXP_W 3
`define LINEAR_W 11
`define PHASE_RES_RESET 7'h00
`define BEMF_CONST_RESET 7'h00
`define LINEAR_RESET 11'h000
`define RES_LOW_RESET 1'h1
`define UNNORM_RESET 1'h0
`define START_VALID_RESET 1'h0
`define LINEAR_MAX 11'h780
`define PHASE_RES_MIN 11'h004
`define BEMF_CONST_MIN 11'h001
`define RES_LSB_MICROOHM 7350
`define BEMF_SCALE_PER_VHZ 1442
`define NORM_MANT_MIN 4'h8
// initial motor state encodings
`define INIT_STATIONARY 2'h0
`define INIT_FORWARD 2'h1
`define INIT_REVERSE 2'h2
`endif

// >>> hdl/param_code_expand.v
// mantissa/exponent to linear value expander
`timescale 1ns/1ps
`include "motor_param_regs.vh"
module param_code_expand (
   // code in
   input wire [`CODE_W-1:0] code_i,
   // linear value out
   output wire [`LINEAR_W-1:0] linear_o,
   output wire normalised_o
);
   wire [`MANT_W-1:0] mant;
   wire [`EXP_W-1:0] expo;
   assign mant = code_i[`MANT_LSB +: `MANT_W];
   assign expo = code_i[`EXP_LSB +: `EXP_W];
   // largest shift 7 of a 4-bit mantissa fits 11 bits exactly
   assign linear_o = {{(`LINEAR_W-`MANT_W){1'h0}}, mant} << expo;
   assign normalised_o = (expo == 3'h0) || (mant >= `NORM_MANT_MIN);
endmodule // param_code_expand

// >>> hdl/motor_param_code_decoder.v
// motor parameter code decoder: holds and expands resistance and back-emf codes
// Operation
// - resistance held as seven-bit host code
// - resistance unit is 7.35 milliohm
// - resistance mantissa shifted by exponent
// - all-ones resistance code gives 1920
// - back-emf held as seven-bit code
// - back-emf linear is 1442 times V/Hz
// - back-emf same format, all-ones gives 1920
// - back-emf code one gives linear one
// - handle stationary, forward, reverse start states
// - resistance in register one, back-emf two
`timescale 1ns/1ps
`include "motor_param_regs.vh"
module motor_param_code_decoder (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // host writes of the parameter registers
   input wire motor_param_reg_one_we_i,
   input wire motor_param_reg_two_we_i,
   input wire [`CODE_W-1:0] wdata_i,
   // start-up initial motor state
   input wire start_req_i,
   input wire [1:0] init_state_i,
   // held codes
   output wire [`CODE_W-1:0] phase_res_code_o,
   output wire [`CODE_W-1:0] bemf_const_code_o,
   // linear values
   output wire [`LINEAR_W-1:0] phase_to_centre_resistance_o,
   output wire [`LINEAR_W-1:0] bemf_const_linear_o,
   // status
   output wire phase_res_low_o,
   output wire code_unnormalised_o,
   output wire [1:0] start_state_o,
   output wire start_valid_o
);
   // stored codes, zero until the host loads them
   reg [`CODE_W-1:0] phase_res_code_reg;
   reg [`CODE_W-1:0] phase_res_code_next;
   reg [`CODE_W-1:0] bemf_const_code_reg;
   reg [`CODE_W-1:0] bemf_const_code_next;
   // registered linear values
   reg [`LINEAR_W-1:0] res_linear_reg;
   reg [`LINEAR_W-1:0] res_linear_next;
   reg [`LINEAR_W-1:0] bemf_linear_reg;
   reg [`LINEAR_W-1:0] bemf_linear_next;
   // registered status
   reg res_low_reg;
   reg res_low_next;
   reg unnorm_reg;
   reg unnorm_next;
   // start request capture
   reg [1:0] start_state_reg;
   reg [1:0] start_state_next;
   reg start_valid_reg;
   reg start_valid_next;
   // expander results
   wire [`LINEAR_W-1:0] res_lin;
   wire [`LINEAR_W-1:0] bemf_lin;
   wire res_norm;
   wire bemf_norm;

   assign phase_res_code_o = phase_res_code_reg;
   assign bemf_const_code_o = bemf_const_code_reg;
   assign phase_to_centre_resistance_o = res_linear_reg;
   assign bemf_const_linear_o = bemf_linear_reg;
   assign phase_res_low_o = res_low_reg;
   assign code_unnormalised_o = unnorm_reg;
   assign start_state_o = start_state_reg;
   assign start_valid_o = start_valid_reg;

   always @* begin
      phase_res_code_next = phase_res_code_reg;
      if (motor_param_reg_one_we_i) begin
         phase_res_code_next = wdata_i;
      end
   end

   // seven-bit back-emf code
   // both enables in one cycle load the same word into each register
   always @* begin
      bemf_const_code_next = bemf_const_code_reg;
      if (motor_param_reg_two_we_i) begin
         bemf_const_code_next = wdata_i;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         phase_res_code_reg <= `PHASE_RES_RESET;
      end else begin
         phase_res_code_reg <= phase_res_code_next;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         bemf_const_code_reg <= `BEMF_CONST_RESET;
      end else begin
         bemf_const_code_reg <= bemf_const_code_next;
      end
   end

   param_code_expand res_expand (
      .code_i(phase_res_code_reg),
      .linear_o(res_lin),
      .normalised_o(res_norm)
   );

   param_code_expand bemf_expand (
      .code_i(bemf_const_code_reg),
      .linear_o(bemf_lin),
      .normalised_o(bemf_norm)
   );

   // one lsb is 7.35 milliohm
   // kept in lsb units; scaling to ohms is left to the consumer
   always @* begin
      res_linear_next = res_lin;
   end

   always @* begin
      bemf_linear_next = bemf_lin;
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         res_linear_reg <= `LINEAR_RESET;
      end else begin
         res_linear_reg <= res_linear_next;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         bemf_linear_reg <= `LINEAR_RESET;
      end else begin
         bemf_linear_reg <= bemf_linear_next;
      end
   end

   // flag unsupported small resistance
   // status only: a value below four is still passed on as written
   always @* begin
      res_low_next = 1'h0;
      if (res_lin < `PHASE_RES_MIN) begin
         res_low_next = 1'h1;
      end
   end

   always @* begin
      unnorm_next = 1'h0;
      if (!res_norm) begin
         unnorm_next = 1'h1;
      end
      if (!bemf_norm) begin
         unnorm_next = 1'h1;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         res_low_reg <= `RES_LOW_RESET;
      end else begin
         res_low_reg <= res_low_next;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         unnorm_reg <= `UNNORM_RESET;
      end else begin
         unnorm_reg <= unnorm_next;
      end
   end

   always @* begin
      start_state_next = start_state_reg;
      start_valid_next = 1'h0;
      if (start_req_i) begin
         start_valid_next = 1'h1;
         case (init_state_i)
            `INIT_FORWARD: begin
               start_state_next = `INIT_FORWARD;
            end
            `INIT_REVERSE: begin
               start_state_next = `INIT_REVERSE;
            end
            `INIT_STATIONARY: begin
               start_state_next = `INIT_STATIONARY;
            end
            // spare encoding treated as stationary, the safe start
            default: begin
               start_state_next = `INIT_STATIONARY;
            end
         endcase
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         start_state_reg <= `INIT_STATIONARY;
      end else begin
         start_state_reg <= start_state_next;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         start_valid_reg <= `START_VALID_RESET;
      end else begin
         start_valid_reg <= start_valid_next;
      end
   end
endmodule // motor_param_code_decoder

// >>> dv/mpcd_monitor.sv
// checker for the motor parameter code decoder
`timescale 1ns/1ps
module mpcd_monitor (
   input wire clk_i, rst_i, start_req_i, start_valid_o,
   input wire motor_param_reg_one_we_i, motor_param_reg_two_we_i,
   input wire [6:0] wdata_i, phase_res_code_o, bemf_const_code_o,
   input wire [1:0] init_state_i, start_state_o,
   input wire [10:0] phase_to_centre_resistance_o, bemf_const_linear_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_c1; motor_param_reg_one_we_i |=> phase_res_code_o == $past(wdata_i); endproperty
   a_c1: assert property (p_c1) else $error("res code");
   property p_c2; motor_param_reg_two_we_i |=> bemf_const_code_o == $past(wdata_i); endproperty
   a_c2: assert property (p_c2) else $error("bemf code");
   property p_l1; phase_to_centre_resistance_o ==
      ({7'h0, $past(phase_res_code_o[3:0])} << $past(phase_res_code_o[6:4])); endproperty
   a_l1: assert property (p_l1) else $error("res linear");
   property p_l2; bemf_const_linear_o ==
      ({7'h0, $past(bemf_const_code_o[3:0])} << $past(bemf_const_code_o[6:4])); endproperty
   a_l2: assert property (p_l2) else $error("bemf linear");
   property p_mx; phase_res_code_o == 7'h7f |=> phase_to_centre_resistance_o == 11'h780; endproperty
   a_mx: assert property (p_mx) else $error("res max");
   property p_mn; bemf_const_code_o == 7'h01 |=> bemf_const_linear_o == 11'h001; endproperty
   a_mn: assert property (p_mn) else $error("bemf min");
   property p_sv; start_req_i |=> start_valid_o && start_state_o ==
      ($past(init_state_i) == 2'h3 ? 2'h0 : $past(init_state_i)); endproperty
   a_sv: assert property (p_sv) else $error("start state");
   property p_sp; !start_req_i |=> !start_valid_o; endproperty
   a_sp: assert property (p_sp) else $error("start pulse");
endmodule // mpcd_monitor
bind motor_param_code_decoder mpcd_monitor mpcd_monitor_i (.*);

// >>> dv/host_model.sv
// host that loads parameter codes
`timescale 1ns/1ps
module host_model (
   input wire clk_i,
   input wire [1:0] sel_i,
   input wire [6:0] code_i,
   output reg we1_o = 1'h0,
   output reg we2_o = 1'h0,
   output reg [6:0] wdata_o = 7'h00
);
   always @(posedge clk_i) begin
      {we2_o, we1_o} <= sel_i;
      // idle data flips each cycle, so a stale code matches only on alternate idle cycles
      wdata_o <= (sel_i != 2'h0) ? code_i : ~wdata_o;
   end
endmodule // host_model

// >>> dv/motor_param_code_decoder_tb_top.sv
// testbench for the motor parameter code decoder
`timescale 1ns/1ps
module motor_param_code_decoder_tb_top;
   reg clk_i = 0, rst_i = 1, st = 0;
   reg [1:0] sel = 0, ini = 0;
   reg [6:0] code = 0;
   wire we1, we2, low, unn, sv;
   wire [6:0] wd, rc, bc;
   wire [10:0] rl, bl;
   wire [1:0] ss;
   integer err_total = 0, cmp_count = 0, i;
   always #2 clk_i = ~clk_i;
   host_model host_model_i (.clk_i(clk_i), .sel_i(sel), .code_i(code), .we1_o(we1),
      .we2_o(we2), .wdata_o(wd));
   motor_param_code_decoder motor_param_code_decoder_i (.clk_i(clk_i), .rst_i(rst_i),
      .motor_param_reg_one_we_i(we1), .motor_param_reg_two_we_i(we2), .wdata_i(wd),
      .start_req_i(st), .init_state_i(ini), .phase_res_code_o(rc), .bemf_const_code_o(bc),
      .phase_to_centre_resistance_o(rl), .bemf_const_linear_o(bl), .phase_res_low_o(low),
      .code_unnormalised_o(unn), .start_state_o(ss), .start_valid_o(sv));
   task chk(input [63:0] nm, input [10:0] e, input [10:0] a); begin
      cmp_count = cmp_count + 1;
      if (a !== e) begin
         err_total = err_total + 1;
         $display("mismatch %0s exp %h got %h", nm, e, a);
      end
   end endtask
   task wr(input [1:0] s, input [6:0] c, input [10:0] l); begin
      @(posedge clk_i) sel <= s;
      code <= c;
      @(posedge clk_i) sel <= 2'h0;
      repeat (3) @(posedge clk_i);
      #1 chk("lin", l, s[0] ? rl : bl);
      chk("code", c, s[0] ? rc : bc);
   end endtask
   task t_res; begin
      @(posedge clk_i) #1 chk("low", 1, low);
      chk("lin", 11'h000, rl);
      wr(2'h1, 7'h7f, 11'h780);
      wr(2'h1, 7'h03, 11'h003);
      chk("low", 1, low);
      wr(2'h1, 7'h2b, 11'h02c);
      chk("low", 0, low);
      $display("t_res done");
   end endtask
   task t_bemf; begin
      wr(2'h2, 7'h01, 11'h001);
      wr(2'h2, 7'h13, 11'h006);
      chk("unnorm", 1, unn);
      wr(2'h3, 7'h5f, 11'h1e0);
      chk("both", 11'h1e0, bl);
      chk("unnorm", 0, unn);
      $display("t_bemf done");
   end endtask
   task t_st; begin
      for (i = 0; i < 5; i = i + 1) begin
         @(posedge clk_i) st <= (i < 4);
         ini <= i;
         #1 if (i > 0) chk("state", (i == 4) ? 0 : i - 1, ss);
         if (i > 0) chk("valid", 1, sv);
      end
      @(posedge clk_i) #1 chk("valid", 0, sv);
      $display("t_st done");
   end endtask
   task print_verdict; begin
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   end endtask
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'h0;
      t_res;
      t_bemf;
      t_st;
      print_verdict;
   end
   // tests need about 55 cycles
   initial begin
      #4000 err_total = err_total + 1;
      print_verdict;
   end
endmodule // motor_param_code_decoder_tb_top
